// ===== hw/dirb_map.svh
// register offsets, field positions, reset values and timing counts for the output/bypass bank
`ifndef DIRB_MAP_SVH
`define DIRB_MAP_SVH
`define DIRB_ADDR_FAST_RATE 8'h4e
`define DIRB_ADDR_INTERP 8'h4f
`define DIRB_ADDR_BYPASS 8'h54
`define DIRB_RESET_FAST_RATE 8'h00
`define DIRB_RESET_INTERP 8'h00
`define DIRB_RESET_BYPASS 8'h00
`define DIRB_DIV_LSB 0
`define DIRB_DIV_MSB 2
`define DIRB_MODE_LSB 3
`define DIRB_MODE_MSB 5
`define DIRB_RATE_LSB 6
`define DIRB_RATE_MSB 7
`define DIRB_SKIP_B_BIT 5
`define DIRB_SKIP_A_BIT 4
`define DIRB_FAST_CORE_SEL 2'h3
`define DIRB_RATE_FULL 2'h0
`define DIRB_RATE_QUARTER 2'h1
`define DIRB_RATE_EIGHTH 2'h2
`define DIRB_FACTOR_FULL 4'h1
`define DIRB_FACTOR_QUARTER 4'h4
`define DIRB_FACTOR_EIGHTH 4'h8
`define DIRB_DIV8 5'h08
`define DIRB_DIV9 5'h09
`define DIRB_DIV10 5'h0a
`define DIRB_DIV12 5'h0c
`define DIRB_DIV14 5'h0e
`define DIRB_DIV16 5'h10
`endif

// ===== hw/dirb_pkg.sv
// types shared by the output interpolation / volume bypass bank
package dirb_pkg;
  typedef enum logic [1:0] {
    DIRB_COMPENSATED,
    DIRB_ZERO_ORDER_HOLD,
    DIRB_LINEAR
  } dirb_interp_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } dirb_req_t;

  typedef struct packed {
    dirb_interp_t output_channel_a;
    dirb_interp_t output_channel_b;
    logic [3:0] rate_factor;
  } dirb_out_cfg_t;

  typedef struct packed {
    logic out_b_volume_skip;
    logic out_a_volume_skip;
    logic in3_volume_skip;
    logic in2_volume_skip;
    logic in1_volume_skip;
    logic in0_volume_skip;
  } dirb_skip_t;

  typedef struct packed {
    logic [4:0] count;
    logic tick;
  } dirb_div_state_t;

  typedef struct packed {
    logic [7:0] fast_rate;
    logic [7:0] output_interp_control;
    logic [7:0] volume_bypass_control;
    logic [2:0] applied_div;
    dirb_out_cfg_t cfg;
    dirb_skip_t skip;
    logic [7:0] rdata;
    logic rvalid;
  } dirb_state_t;
endpackage

// ===== hw/dirb_rate_div.sv
// fast-rate tick generator dividing the master clock by the period (8 to 16) that the applied code selects
`timescale 1ns/10ps
`include "dirb_map.svh"
module dirb_rate_div (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic clk_en_in,
  input wire logic run_in,
  input wire logic [2:0] div_code_in,
  output logic tick_out
);
  dirb_pkg::dirb_div_state_t state;
  dirb_pkg::dirb_div_state_t next_state;
  logic [4:0] period;

  always_comb begin
    case (div_code_in)
      3'h0: period = `DIRB_DIV8;
      3'h1: period = `DIRB_DIV9;
      3'h2: period = `DIRB_DIV10;
      3'h3: period = `DIRB_DIV12;
      3'h4: period = `DIRB_DIV14;
      3'h5: period = `DIRB_DIV16;
      default: period = `DIRB_DIV8;
    endcase
  end

  always_comb begin
    next_state = state;
    next_state.tick = 1'b0;
    if (!run_in) begin
      next_state.count = 5'h00;
    end else if (state.count >= period - 5'h01) begin
      next_state.count = 5'h00;
      next_state.tick = 1'b1;
    end else begin
      next_state.count = state.count + 5'h01;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= '0;
    end else if (clk_en_in) begin
      state <= next_state;
    end
  end

  assign tick_out = state.tick;
endmodule

// ===== hw/dirb_regs.sv
// output interpolation, fast-rate divider and volume bypass register bank
`timescale 1ns/10ps
`include "dirb_map.svh"
module dirb_regs (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic clk_en_in,
  input wire dirb_pkg::dirb_req_t req_in,
  input wire logic core_run_in,
  input wire logic [1:0] core_rate_select_in,
  output logic [7:0] rdata_out,
  output logic rvalid_out,
  output logic [2:0] applied_div_out,
  output logic fast_tick_out,
  output dirb_pkg::dirb_out_cfg_t out_cfg_out,
  output dirb_pkg::dirb_skip_t skip_out
);
  localparam int SKIP_W = 6;
  dirb_pkg::dirb_state_t state;
  dirb_pkg::dirb_state_t next_state;
  logic [2:0] mode;
  logic [1:0] rate;
  logic wr_fast;
  logic wr_interp;
  logic wr_bypass;
  logic [7:0] read_word;
  logic [2:0] next_div;
  logic [3:0] rate_factor;
  dirb_pkg::dirb_interp_t interp_a;
  dirb_pkg::dirb_interp_t interp_b;
  logic [SKIP_W-1:0] skip_bits;

  // ----------------------------------------
  // write address decode
  // ----------------------------------------
  always_comb begin
    // a write to an unmapped offset selects nothing and is dropped
    wr_fast = 1'b0;
    wr_interp = 1'b0;
    wr_bypass = 1'b0;
    if (req_in.addr == `DIRB_ADDR_FAST_RATE) begin
      wr_fast = req_in.wr;
    end else if (req_in.addr == `DIRB_ADDR_INTERP) begin
      wr_interp = req_in.wr;
    end else if (req_in.addr == `DIRB_ADDR_BYPASS) begin
      wr_bypass = req_in.wr;
    end
  end

  // ----------------------------------------
  // read data select
  // ----------------------------------------
  always_comb begin
    if (req_in.addr == `DIRB_ADDR_FAST_RATE) begin
      read_word = state.fast_rate;
    end else if (req_in.addr == `DIRB_ADDR_INTERP) begin
      read_word = state.output_interp_control;
    end else if (req_in.addr == `DIRB_ADDR_BYPASS) begin
      read_word = state.volume_bypass_control;
    end else begin
      // unmapped offsets read as zero
      read_word = 8'h00;
    end
  end

  // ----------------------------------------
  // divider code hand-off
  // ----------------------------------------
  always_comb begin
    // the code is frozen while the core runs so the tick period never shifts under it
    next_div = state.applied_div;
    if (!core_run_in) begin
      next_div = state.fast_rate[`DIRB_DIV_MSB:`DIRB_DIV_LSB];
    end
  end

  // ----------------------------------------
  // output converter rate decode
  // ----------------------------------------
  always_comb begin
    rate = state.output_interp_control[`DIRB_RATE_MSB:`DIRB_RATE_LSB];
    case (rate)
      `DIRB_RATE_FULL: rate_factor = `DIRB_FACTOR_FULL;
      `DIRB_RATE_QUARTER: rate_factor = `DIRB_FACTOR_QUARTER;
      `DIRB_RATE_EIGHTH: rate_factor = `DIRB_FACTOR_EIGHTH;
      // reserved code 11 falls back to the core rate
      default: rate_factor = `DIRB_FACTOR_FULL;
    endcase
  end

  // ----------------------------------------
  // interpolation mode decode
  // ----------------------------------------
  always_comb begin
    mode = state.output_interp_control[`DIRB_MODE_MSB:`DIRB_MODE_LSB];
    case (mode)
      3'h0: begin
        interp_a = dirb_pkg::DIRB_COMPENSATED;
        interp_b = dirb_pkg::DIRB_COMPENSATED;
      end
      3'h1: begin
        interp_a = dirb_pkg::DIRB_ZERO_ORDER_HOLD;
        interp_b = dirb_pkg::DIRB_COMPENSATED;
      end
      3'h2: begin
        interp_a = dirb_pkg::DIRB_COMPENSATED;
        interp_b = dirb_pkg::DIRB_ZERO_ORDER_HOLD;
      end
      3'h3: begin
        interp_a = dirb_pkg::DIRB_ZERO_ORDER_HOLD;
        interp_b = dirb_pkg::DIRB_ZERO_ORDER_HOLD;
      end
      3'h4: begin
        interp_a = dirb_pkg::DIRB_LINEAR;
        interp_b = dirb_pkg::DIRB_COMPENSATED;
      end
      3'h5: begin
        interp_a = dirb_pkg::DIRB_COMPENSATED;
        interp_b = dirb_pkg::DIRB_LINEAR;
      end
      3'h6: begin
        interp_a = dirb_pkg::DIRB_LINEAR;
        interp_b = dirb_pkg::DIRB_LINEAR;
      end
      default: begin
        // undefined code 111 falls back to both compensated
        interp_a = dirb_pkg::DIRB_COMPENSATED;
        interp_b = dirb_pkg::DIRB_COMPENSATED;
      end
    endcase
  end

  // ----------------------------------------
  // volume bypass decode, one bit per channel
  // ----------------------------------------
  for (genvar g = 0; g < SKIP_W; g++) begin : g_skip
    // bit 5 is output B, bit 4 output A, bits 3..0 input channels 3..0
    assign skip_bits[g] = state.volume_bypass_control[g];
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_state.rvalid = 1'b0;
    if (wr_fast) begin
      next_state.fast_rate = req_in.wdata;
    end
    if (wr_interp) begin
      next_state.output_interp_control = req_in.wdata;
    end
    if (wr_bypass) begin
      next_state.volume_bypass_control = req_in.wdata;
    end
    // a read in the same cycle as a write returns the old value
    if (req_in.rd) begin
      next_state.rvalid = 1'b1;
      next_state.rdata = read_word;
    end
    next_state.applied_div = next_div;
    // decoded settings lag the register by one clock
    next_state.cfg.output_channel_a = interp_a;
    next_state.cfg.output_channel_b = interp_b;
    next_state.cfg.rate_factor = rate_factor;
    next_state.skip = skip_bits;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= '0;
      state.fast_rate <= `DIRB_RESET_FAST_RATE;
      state.output_interp_control <= `DIRB_RESET_INTERP;
      state.volume_bypass_control <= `DIRB_RESET_BYPASS;
      state.cfg.rate_factor <= `DIRB_FACTOR_FULL;
    end else if (clk_en_in) begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // fast-rate divider
  // ----------------------------------------
  dirb_rate_div u_div (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .clk_en_in(clk_en_in),
    .run_in(core_rate_select_in == `DIRB_FAST_CORE_SEL),
    .div_code_in(state.applied_div),
    .tick_out(fast_tick_out)
  );

  // ----------------------------------------
  // output drive
  // ----------------------------------------
  assign rdata_out = state.rdata;
  assign rvalid_out = state.rvalid;
  assign applied_div_out = state.applied_div;
  assign out_cfg_out = state.cfg;
  assign skip_out = state.skip;
endmodule

// ===== verif/dirb_regs_properties.sv
// concurrent checks on the register bank ports
`timescale 1ns/10ps
module dirb_regs_chk (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic clk_en_in,
  input wire dirb_pkg::dirb_req_t req_in,
  input wire logic core_run_in,
  input wire logic [1:0] core_rate_select_in,
  input wire logic [7:0] rdata_out,
  input wire logic rvalid_out,
  input wire logic [2:0] applied_div_out,
  input wire logic fast_tick_out,
  input wire dirb_pkg::dirb_out_cfg_t out_cfg_out,
  input wire dirb_pkg::dirb_skip_t skip_out
);
  // ----
  // tick spacing helper
  // ----
  logic [4:0] gap;
  logic [4:0] want;
  logic armed;
  assign want = applied_div_out < 3'h2 ? 5'h08 + {2'h0, applied_div_out} :
    applied_div_out < 3'h6 ? 5'h06 + {1'h0, applied_div_out, 1'h0} : 5'h08;
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      gap <= 5'h00;
      armed <= 1'b0;
    end else begin
      gap <= fast_tick_out ? 5'h01 : gap + 5'h01;
      armed <= (armed | fast_tick_out) & clk_en_in & core_run_in & (core_rate_select_in == 2'h3);
    end
  end
  // ----
  // properties
  // ----
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (!resetn_in);
  sequence s_wr(logic [7:0] a);
    clk_en_in && req_in.wr && req_in.addr == a ##1 clk_en_in;
  endsequence
  a_read_answer: assert property (clk_en_in && req_in.rd |=> rvalid_out) else $error("read unanswered");
  a_unmapped_zero: assert property (clk_en_in && req_in.rd && req_in.addr == 8'h50 |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  a_skip_follow: assert property (s_wr(8'h54) |=> skip_out == $past(req_in.wdata[5:0], 2))
    else $error("bypass outputs wrong");
  a_mode_zoh: assert property ((req_in.wdata[5:3] == 3'h3) ##0 s_wr(8'h4f) |=> out_cfg_out[7:4] == 4'h5)
    else $error("hold mode wrong");
  a_mode_linear: assert property ((req_in.wdata[5:3] == 3'h6) ##0 s_wr(8'h4f) |=> out_cfg_out[7:4] == 4'ha)
    else $error("linear mode wrong");
  a_rate_quarter: assert property ((req_in.wdata[7:6] == 2'h1) ##0 s_wr(8'h4f) |=> out_cfg_out[3:0] == 4'h4)
    else $error("rate factor wrong");
  a_div_load: assert property (!core_run_in ##0 s_wr(8'h4e) ##0 !core_run_in
    |=> applied_div_out == $past(req_in.wdata[2:0], 2)) else $error("divider code not loaded");
  a_div_hold: assert property (core_run_in |=> $stable(applied_div_out)) else $error("divider moved");
  a_tick_gap: assert property (fast_tick_out && armed |-> gap == want) else $error("tick spacing");
  a_tick_idle: assert property ((core_rate_select_in != 2'h3)[*2] |-> !fast_tick_out)
    else $error("tick while idle");
endmodule
bind dirb_regs dirb_regs_chk u_chk (.mclk_in, .resetn_in, .clk_en_in, .req_in, .core_run_in, .core_rate_select_in,
  .rdata_out, .rvalid_out, .applied_div_out, .fast_tick_out, .out_cfg_out, .skip_out);

// ===== verif/testbench.sv
// self-checking bench for the register bank
`timescale 1ns/10ps
module testbench;
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic clk_en_in = 1'b1;
  logic core_run_in = 1'b0;
  logic [1:0] core_rate_select_in = 2'h3;
  dirb_pkg::dirb_req_t req_in = '0;
  logic [7:0] rdata_out;
  logic rvalid_out, fast_tick_out;
  logic [2:0] applied_div_out;
  dirb_pkg::dirb_out_cfg_t out_cfg_out;
  dirb_pkg::dirb_skip_t skip_out;
  int fails = 0;
  int samples_checked = 0;
  int n;
  // address, write data, expected decode
  logic [23:0] rows [9] = '{24'h4f0001, 24'h4f4844, 24'h4f9018, 24'h4f1d51, 24'h4f2081, 24'h4f2821,
    24'h4f70a4, 24'h543030, 24'h54cf0f};
  logic [7:0] divs [6] = '{8'h08, 8'h09, 8'h0a, 8'h0c, 8'h0e, 8'h10};
  always #50 mclk_in = ~mclk_in;
  dirb_regs uut (.mclk_in, .resetn_in, .clk_en_in, .req_in, .core_run_in, .core_rate_select_in,
    .rdata_out, .rvalid_out, .applied_div_out, .fast_tick_out, .out_cfg_out, .skip_out);
  // ----
  // tasks
  // ----
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    req_in = {a, d, 2'b10};
    @(negedge mclk_in);
    req_in = '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk_in);
    req_in = {a, 8'h00, 2'b01};
    @(negedge mclk_in);
    // the read answer stands for one clock only
    chk({7'h00, rvalid_out}, 8'h01);
    chk(rdata_out, exp);
    req_in = '0;
  endtask
  task automatic tick_gap(output int k);
    k = 0;
    while (fast_tick_out !== 1'b1 && k < 40) begin
      @(negedge mclk_in);
      k++;
    end
    k = 0;
    do begin
      @(negedge mclk_in);
      k++;
    end while (fast_tick_out !== 1'b1 && k < 40);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ----
  // sequence
  // ----
  initial begin
    repeat (6) @(negedge mclk_in);
    resetn_in = 1'b1;
    rd(8'h4f, 8'h00);
    rd(8'h54, 8'h00);
    chk(8'(out_cfg_out), 8'h01);
    chk(8'(skip_out), 8'h00);
    for (int i = 0; i < 9; i++) begin
      wr(rows[i][23:16], rows[i][15:8]);
      @(negedge mclk_in);
      chk(rows[i][23:16] == 8'h4f ? 8'(out_cfg_out) : 8'(skip_out), rows[i][7:0]);
      rd(rows[i][23:16], rows[i][15:8]);
    end
    rd(8'h50, 8'h00);
    clk_en_in = 1'b0;
    wr(8'h54, 8'h3f);
    clk_en_in = 1'b1;
    rd(8'h54, 8'hcf);
    for (int j = 0; j < 6; j++) begin
      core_run_in = 1'b0;
      wr(8'h4e, 8'(j));
      @(negedge mclk_in);
      core_run_in = 1'b1;
      tick_gap(n);
      tick_gap(n);
      chk(n[7:0], divs[j]);
    end
    wr(8'h4e, 8'h00);
    repeat (2) @(negedge mclk_in);
    chk({5'h00, applied_div_out}, 8'h05);
    core_run_in = 1'b0;
    repeat (2) @(negedge mclk_in);
    chk({5'h00, applied_div_out}, 8'h00);
    core_rate_select_in = 2'h2;
    n = 0;
    repeat (30) begin
      @(negedge mclk_in);
      if (fast_tick_out !== 1'b0) n++;
    end
    chk(n[7:0], 8'h00);
    tally_and_finish();
  end
  initial begin
    #1000000;
    fails++;
    tally_and_finish();
  end
endmodule
